// [logic/sbc_pkg.sv]
// Package: timing constants and command codes for the SRAM bulk-clear host
package sbc_pkg;
	localparam int CLK_PERIOD_NS = 40;
	// Figures for the slowest speed grade, safe for all grades
	localparam int T_ADDR_SETUP_NS  = 5;
	localparam int T_WRITE_PULSE_NS = 20;
	localparam int T_DATA_SETUP_NS  = 20;
	localparam int T_HOLD_NS        = 5;
	localparam int T_CLR_PULSE_NS   = 30;
	localparam int T_CLR_HOLD_NS    = 40;
	localparam int T_READ_ACCESS_NS = 35;
	localparam int T_CLR_DONE_NS    = 70;
	// Least times round up, never below one cycle
	function automatic int cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int N_ADDR_SETUP  = cyc(T_ADDR_SETUP_NS);
	localparam int N_WRITE_PULSE = cyc(T_WRITE_PULSE_NS);
	localparam int N_HOLD        = cyc(T_HOLD_NS);
	localparam int N_CLR_PULSE   = cyc(T_CLR_PULSE_NS);
	localparam int N_CLR_HOLD    = cyc(T_CLR_HOLD_NS);
	localparam int N_READ_ACCESS = cyc(T_READ_ACCESS_NS);
	localparam int N_CLR_DONE    = cyc(T_CLR_DONE_NS);
	localparam int CNT_W         = 4;
	localparam logic [1:0] CMD_READ  = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_CLEAR = 2'h2;
	typedef enum {
		ST_IDLE, ST_RD_ACC, ST_WR_SET, ST_WR_PULSE, ST_WR_HOLD,
		ST_CL_SET, ST_CL_PULSE, ST_CL_HOLD
	} sbc_state_type;
endpackage

// [logic/sbc_host.sv]
// Host controller driving a 1024x4 separate-I/O SRAM with bulk clear
//
// Function
// RULE_01 - Write only while select and strobe low
// RULE_02 - Write ends when either strobe rises
// RULE_03 - Data stable before write-ending edge
// RULE_04 - Data held after write-ending edge
// RULE_05 - Address stable before write strobe overlap
// RULE_06 - Address held after write ends
// RULE_07 - Joint strobe rise keeps outputs floating
// RULE_08 - Clear is clear-low overlapping select-low, minimum
// RULE_09 - Address, strobe high, select low before clear
// RULE_10 - Strobe high for hold after clear
// RULE_11 - Address stable for hold after clear
// RULE_12 - Select low at clear end, zero hold
// RULE_13 - Outputs float while clear is low
// RULE_14 - Read data valid after address access
// RULE_15 - Old data held briefly after address change
// RULE_16 - Read data valid after select falls
// RULE_17 - Read data valid after output enable falls
// RULE_18 - Clear zeroes whole array within two cycles
// RULE_19 - Read needs select low, strobe high, enable low
// RULE_20 - Outputs float when deselected, clearing, disabled, writing
// RULE_21 - Written data appears on outputs afterwards
`timescale 1ns/100ps
module sbc_host #(
	parameter int ADDR_W = 10,
	parameter int DATA_W = 4
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic [1:0]        req_cmd,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_rdata,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic                   device_select_n,
	output logic                   write_strobe_n,
	output logic                   output_drive_enable_n,
	output logic                   clear_all_n,
	output logic [DATA_W-1:0]      write_data_in,
	input  wire logic [DATA_W-1:0] read_data_out
);
	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	sbc_pkg::sbc_state_type          state_r, state_nxt;
	logic [sbc_pkg::CNT_W-1:0]       cnt_r, cnt_nxt;
	logic [ADDR_W-1:0]               addr_r, addr_nxt;
	logic [DATA_W-1:0]               wdat_r, wdat_nxt;
	logic [DATA_W-1:0]               rdat_r, rdat_nxt;
	logic                            cs_r, cs_nxt;
	logic                            we_r, we_nxt;
	logic                            oe_r, oe_nxt;
	logic                            clr_r, clr_nxt;
	logic                            rv_r, rv_nxt;

	localparam logic [sbc_pkg::CNT_W-1:0] C_ONE = 4'h1;

	function automatic logic [sbc_pkg::CNT_W-1:0] cn(input int n);
		return sbc_pkg::CNT_W'(n);
	endfunction

	assign req_ready = (state_r == sbc_pkg::ST_IDLE);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		addr_nxt  = addr_r;
		wdat_nxt  = wdat_r;
		rdat_nxt  = rdat_r;
		cs_nxt    = cs_r;
		we_nxt    = we_r;
		oe_nxt    = oe_r;
		clr_nxt   = clr_r;
		rv_nxt    = 1'b0;
		case (state_r)
			sbc_pkg::ST_IDLE: begin
				// Address and data change only here, strobes all idle
				cs_nxt  = 1'b1;
				oe_nxt  = 1'b1;
				we_nxt  = 1'b1;
				clr_nxt = 1'b1;
				if (req_valid) begin
					addr_nxt = req_addr;
					wdat_nxt = req_wdata;
					cs_nxt   = 1'b0;
					case (req_cmd)
						sbc_pkg::CMD_WRITE: begin
							// Select first, strobe a setup later [RULE_05]
							state_nxt = sbc_pkg::ST_WR_SET;
							cnt_nxt   = cn(sbc_pkg::N_ADDR_SETUP);
						end
						sbc_pkg::CMD_CLEAR: begin
							// Strobe high, select low before clear [RULE_09]
							state_nxt = sbc_pkg::ST_CL_SET;
							cnt_nxt   = C_ONE;
						end
						default: begin
							// Read: select and enable with strobe high [RULE_19]
							oe_nxt    = 1'b0;
							state_nxt = sbc_pkg::ST_RD_ACC;
							cnt_nxt   = cn(sbc_pkg::N_READ_ACCESS);
						end
					endcase
				end
			end
			sbc_pkg::ST_RD_ACC: begin
				// Wait out the longest of the access times [RULE_14] [RULE_16] [RULE_17]
				if (cnt_r == C_ONE) begin
					rdat_nxt  = read_data_out;
					rv_nxt    = 1'b1;
					cs_nxt    = 1'b1;
					oe_nxt    = 1'b1;
					state_nxt = sbc_pkg::ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - C_ONE;
				end
			end
			sbc_pkg::ST_WR_SET: begin
				if (cnt_r == C_ONE) begin
					// Overlap of select and strobe is the write [RULE_01]
					we_nxt    = 1'b0;
					state_nxt = sbc_pkg::ST_WR_PULSE;
					cnt_nxt   = cn(sbc_pkg::N_WRITE_PULSE);
				end else begin
					cnt_nxt = cnt_r - C_ONE;
				end
			end
			sbc_pkg::ST_WR_PULSE: begin
				// Data has stood since select fell, well over setup [RULE_03]
				if (cnt_r == C_ONE) begin
					// Strobe alone ends the write, select stays low [RULE_02]
					we_nxt    = 1'b1;
					state_nxt = sbc_pkg::ST_WR_HOLD;
					cnt_nxt   = cn(sbc_pkg::N_HOLD);
				end else begin
					cnt_nxt = cnt_r - C_ONE;
				end
			end
			sbc_pkg::ST_WR_HOLD: begin
				// Address and data held past write end [RULE_04] [RULE_06]
				if (cnt_r == C_ONE) begin
					cs_nxt    = 1'b1;
					state_nxt = sbc_pkg::ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - C_ONE;
				end
			end
			sbc_pkg::ST_CL_SET: begin
				// Clear pulse overlapping select [RULE_08]
				clr_nxt   = 1'b0;
				state_nxt = sbc_pkg::ST_CL_PULSE;
				cnt_nxt   = cn(sbc_pkg::N_CLR_PULSE);
			end
			sbc_pkg::ST_CL_PULSE: begin
				if (cnt_r == C_ONE) begin
					clr_nxt   = 1'b1;
					state_nxt = sbc_pkg::ST_CL_HOLD;
					// Cover both hold and full clear cycle [RULE_18]
					cnt_nxt   = cn(sbc_pkg::N_CLR_HOLD > sbc_pkg::N_CLR_DONE ?
						sbc_pkg::N_CLR_HOLD : sbc_pkg::N_CLR_DONE);
				end else begin
					cnt_nxt = cnt_r - C_ONE;
				end
			end
			sbc_pkg::ST_CL_HOLD: begin
				// Strobe high, address and select held [RULE_10] [RULE_11] [RULE_12]
				if (cnt_r == C_ONE) begin
					cs_nxt    = 1'b1;
					state_nxt = sbc_pkg::ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - C_ONE;
				end
			end
			default: begin
				state_nxt = sbc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_r <= sbc_pkg::ST_IDLE;
			cnt_r   <= '0;
			addr_r  <= '0;
			wdat_r  <= '0;
			rdat_r  <= '0;
			cs_r    <= 1'b1;
			we_r    <= 1'b1;
			oe_r    <= 1'b1;
			clr_r   <= 1'b1;
			rv_r    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			addr_r  <= addr_nxt;
			wdat_r  <= wdat_nxt;
			rdat_r  <= rdat_nxt;
			cs_r    <= cs_nxt;
			we_r    <= we_nxt;
			oe_r    <= oe_nxt;
			clr_r   <= clr_nxt;
			rv_r    <= rv_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Pins
	// ---------------------------------------------------------------
	// Enable stays high during writes and clears, so device floats [RULE_20]
	assign mem_addr              = addr_r;
	assign device_select_n       = cs_r;
	assign write_strobe_n        = we_r;
	assign output_drive_enable_n = oe_r;
	assign clear_all_n           = clr_r;
	assign write_data_in         = wdat_r;
	assign rsp_valid             = rv_r;
	assign rsp_rdata             = rdat_r;
endmodule

// [sim/sbc_host_monitor.sv]
// Checker of the host pin sequencing
`timescale 1ns/100ps
module sbc_host_monitor (
	input logic       clk_sys,
	input logic       rst_b,
	input logic       req_valid,
	input logic       req_ready,
	input logic [1:0] req_cmd,
	input logic       rsp_valid,
	input logic [9:0] mem_addr,
	input logic       device_select_n,
	input logic       write_strobe_n,
	input logic       output_drive_enable_n,
	input logic       clear_all_n,
	input logic [3:0] write_data_in
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_write_in_select: assert property (
		!write_strobe_n |-> !device_select_n) else $error("write unselected");
	a_strobe_ends_write: assert property (
		$rose(write_strobe_n) |-> !device_select_n) else $error("write end");
	a_write_setup_ok: assert property (
		!write_strobe_n |-> $stable(write_data_in) && $stable(mem_addr))
		else $error("write setup");
	a_write_hold_ok: assert property (
		$rose(write_strobe_n) |-> $stable(write_data_in) && $stable(mem_addr))
		else $error("write hold");
	a_clear_setup_ok: assert property (
		!clear_all_n |-> !device_select_n && write_strobe_n)
		else $error("clear setup");
	a_clear_overlap: assert property (
		$fell(clear_all_n) |-> ##1 !device_select_n && clear_all_n)
		else $error("clear pulse");
	a_clear_hold_ok: assert property (
		$rose(clear_all_n) |-> !device_select_n ##1
		write_strobe_n && $stable(mem_addr)) else $error("clear hold");
	a_enable_read_only: assert property (
		!output_drive_enable_n |-> !device_select_n && write_strobe_n
		&& clear_all_n) else $error("enable misuse");
	a_read_answer: assert property (
		req_valid && req_ready && (req_cmd == 2'h0 || req_cmd == 2'h3)
		|-> ##2 rsp_valid) else $error("read answer");
endmodule
bind sbc_host sbc_host_monitor sbc_host_monitor_inst (.clk_sys, .rst_b,
	.req_valid, .req_ready, .req_cmd, .rsp_valid, .mem_addr,
	.device_select_n, .write_strobe_n, .output_drive_enable_n,
	.clear_all_n, .write_data_in);

// [sim/sbc_sram_model.sv]
// Behavioural 1024x4 memory with bulk clear
`timescale 1ns/100ps
module sbc_sram_model (
	input logic [9:0]  mem_addr,
	input logic        device_select_n,
	input logic        write_strobe_n,
	input logic        output_drive_enable_n,
	input logic        clear_all_n,
	input logic [3:0]  write_data_in,
	output logic [3:0] read_data_out
);
	logic [3:0] mem [1024];
	logic [3:0] last = 4'h0;
	logic       drv;
	always @(posedge write_strobe_n)
		if (!device_select_n) mem[mem_addr] = write_data_in;
	always @(posedge device_select_n)
		if (!write_strobe_n) mem[mem_addr] = write_data_in;
	always @(negedge clear_all_n)
		if (!device_select_n) foreach (mem[i]) mem[i] = 4'h0;
	assign drv = !device_select_n && write_strobe_n && clear_all_n
		&& !output_drive_enable_n;
	always @* if (drv) last = mem[mem_addr];
	// Floating pins show the inverse, so a late sample cannot pass
	assign #10 read_data_out = drv ? mem[mem_addr] : ~last;
	// Delay also covers access from select and enable
	// Write data reads back once the cycle ends
endmodule

// [sim/test_sbc_host.sv]
// Self-checking bench for the memory host
`timescale 1ns/100ps
module test_sbc_host;
	logic       clk_sys = 1'b0;
	logic       rst_b = 1'b0;
	logic       req_valid = 1'b0;
	logic [1:0] req_cmd = 2'h0;
	logic [9:0] req_addr = 10'h000;
	logic [3:0] req_wdata = 4'h0;
	logic       req_ready, rsp_valid, device_select_n, write_strobe_n;
	logic       output_drive_enable_n, clear_all_n;
	logic [3:0] rsp_rdata, write_data_in, read_data_out;
	logic [9:0] mem_addr;
	int         errors = 0, compares = 0, ref_mem[1024];
	sbc_host sbc_host_inst (.clk_sys, .rst_b, .req_valid, .req_ready,
		.req_cmd, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
		.mem_addr, .device_select_n, .write_strobe_n,
		.output_drive_enable_n, .clear_all_n, .write_data_in,
		.read_data_out);
	sbc_sram_model sbc_sram_model_inst (.mem_addr, .device_select_n,
		.write_strobe_n, .output_drive_enable_n, .clear_all_n,
		.write_data_in, .read_data_out);
	initial forever #20 clk_sys = ~clk_sys;
	task automatic chk(input string name, input logic [3:0] got,
		input logic [3:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic conclude;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Request held until an edge sees ready; reads await the answer
	task automatic go(input logic [1:0] c, input int a, input int d);
		req_valid <= 1'b1;
		req_cmd <= c;
		req_addr <= 10'(a);
		req_wdata <= 4'(d);
		do @(posedge clk_sys); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		if (c == 2'h2) ref_mem = '{default: 0};
		if (c == 2'h1) ref_mem[a] = d % 16;
		if (c[0] == c[1]) begin
			for (int i = 0; i < 4 && rsp_valid !== 1'b1; i++)
				@(posedge clk_sys);
			chk("rsp_valid", {3'h0, rsp_valid}, 4'h1);
			chk("rsp_rdata", rsp_rdata, 4'(ref_mem[a]));
		end else
			@(posedge clk_sys);
	endtask
	initial begin
		int a;
		void'($urandom(32'hFA662CC5));
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			a = (i < 2) ? i * 1023 : $urandom % 1024;
			go(2'h1, a, $urandom % 16);
			go((i == 2) ? 2'h3 : 2'h0, a, 0);
		end
		go(2'h2, 0, 0);
		go(2'h0, 0, 0);
		go(2'h0, 1023, 0);
		go(2'h0, a, 0);
		go(2'h1, a, 10);
		go(2'h0, a, 0);
		conclude;
	end
	initial begin
		#(40 * 3000);
		errors++;
		conclude;
	end
endmodule
